// ---- src/sfqe_engine.sv ----
`timescale 1ns/10ps
// What this block does
// [R1] Receive words move into the buffer eight bytes at a time
// [R2] Switch request only after end of frame with good status
// [R3] Round robin over receive ports, first 64 bytes held for search
// [R4] Search answer gives unicast/multicast and ports, then admission
// [R5] Two class queues per fast port, four for gigabit and cpu
// [R6] Unicast goes to linked list, multicast into its own queue
// [R7] Older head of list and multicast queue is served first
// [R8] Ready port takes a head entry chosen by the scheduler
// [R9] Transmit mover streams frame words to the port queue
// [R10] Handles given per frame, freed on departure, reserve enforced
// [R11] Buffer is allocated and freed in 128 byte blocks
// [R12] Init chains all blocks into free list, releases relink
// [R13] Size limit 1518 or 1522, up to 4K with extended bit 1
// [R14] Drop on queue or reserve shortage, no blocking if no pause
// [R15] Multicast write sets the copy count of the frame
// [R16] Flow control toward source only when enabled for that port
// [R17] Scheduled frame info goes to the destination port control
// [R18] Read addresses generated, start and end flags written
// [R19] Finished transmission requests release of the buffer
// [R20] One mover multiplexes ports and arbitrates releases
// [R21] No forwarding between two protected fast ports
// [R22] Strict priority: lower class only when higher are empty
// [R23] Long frames chain blocks, freed together at last copy
module sfqe_engine #(
  parameter int NP   = 4,
  parameter int NBLK = 64,
  parameter int BW   = 6,
  parameter int QH   = 32
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [NP-1:0]     rx_valid_i,
  input  wire logic [NP*64-1:0]  rx_data_i,
  input  wire logic [NP-1:0]     rx_sof_i,
  input  wire logic [NP-1:0]     rx_eof_i,
  input  wire logic [NP-1:0]     rx_good_i,
  input  wire logic [NP-1:0]     rx_tagged_i,
  input  wire logic [NP*3-1:0]   rx_last_bytes_i,
  output logic      [NP-1:0]     rx_ready_o,
  output logic                   sreq_valid_o,
  input  wire logic              sreq_ready_i,
  output logic      [BW-1:0]     sreq_handle_o,
  output logic      [1:0]        sreq_port_o,
  output logic      [511:0]      sreq_hdr_o,
  input  wire logic              srsp_valid_i,
  input  wire logic [BW-1:0]     srsp_handle_i,
  input  wire logic              srsp_multi_i,
  input  wire logic [NP-1:0]     srsp_dest_i,
  input  wire logic [1:0]        srsp_class_i,
  input  wire logic [NP-1:0]     fc_enable_i,
  input  wire logic [NP-1:0]     protect_i,
  input  wire logic [NP*8-1:0]   ext_ctrl_i,
  input  wire logic [12:0]       buf_limit_i,
  input  wire logic [BW:0]       resv_blocks_i,
  input  wire logic [7:0]        queue_limit_i,
  output logic      [NP-1:0]     fc_o,
  output logic                   drop_o,
  output logic      [BW:0]       free_blocks_o,
  input  wire logic [NP-1:0]     tx_ready_i,
  input  wire logic              tx_take_i,
  output logic                   tx_valid_o,
  output logic      [1:0]        tx_port_o,
  output logic      [63:0]       tx_data_o,
  output logic                   tx_sof_o,
  output logic                   tx_eof_o,
  output logic      [9:0]        tx_len_o
);
  localparam int NQ = NP * sfqe_pkg::MAX_CLS;
  localparam int MD = sfqe_pkg::MC_DEPTH;
  localparam int MW = sfqe_pkg::MAX_WORDS;

  // [R5] class count per port
  function automatic int ncls(input int p);
    return (p >= NP - 2) ? sfqe_pkg::WIDE_CLS : sfqe_pkg::FAST_CLS;
  endfunction

  function automatic int qidx(input int p, input logic [1:0] c);
    return p * sfqe_pkg::MAX_CLS + ((int'(c) >= ncls(p)) ?
           ncls(p) - 1 : int'(c));
  endfunction

  // Wrap-safe age compare on enqueue stamps
  function automatic logic older(input logic [15:0] a,
                                 input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    return d[15];
  endfunction

  // Buffer, block links and frame control store
  logic [63:0]   mem   [NBLK*sfqe_pkg::BLK_WORDS];
  logic [BW-1:0] lnk   [NBLK];
  logic [BW-1:0] unx   [NBLK];
  logic [9:0]    f_len [NBLK];
  logic [BW-1:0] f_tl  [NBLK];
  logic [BW:0]   f_nb  [NBLK];
  logic [1:0]    f_src [NBLK];
  logic [NP:0]   f_dup [NBLK];
  logic [15:0]   f_stp [NBLK];
  logic [63:0]   hdr   [sfqe_pkg::HDR_WORDS];
  logic [BW-1:0] mf    [NQ*MD];
  logic [BW-1:0] uhd   [NQ];
  logic [BW-1:0] utl   [NQ];
  logic [7:0]    ucnt  [NQ];
  logic [2:0]    mcnt  [NQ];
  logic [1:0]    mrd   [NQ];
  logic [1:0]    mwr   [NQ];

  sfqe_pkg::sfqe_rx_type rst, next_rst;
  sfqe_pkg::sfqe_tx_type tst, next_tst;
  logic [1:0]    rsel, next_rsel, trr, next_trr;
  logic [9:0]    rwc, next_rwc, tsent, next_tsent;
  logic [BW-1:0] rblk, next_rblk, rh, next_rh, fh, next_fh;
  logic [BW-1:0] th, next_th, tblk, next_tblk;
  logic [BW:0]   rnb, next_rnb, fcnt, next_fcnt;
  logic          rbad, next_rbad, next_sv, next_drop;
  logic [NP-1:0] next_fc;
  logic [15:0]   stmp;
  logic [63:0]   next_data;
  logic          next_tv, next_sof, next_eof;
  logic [1:0]    next_tp;
  logic [9:0]    next_tlen;
  logic          rx_acc, rx_alloc, rx_rel, rx_ok, wr_en;
  logic          rs_rel, tx_gnt, rel_v, ld;
  logic [BW-1:0] rel_h, rel_t;
  logic [BW:0]   rel_n;
  logic [NP-1:0] enq;
  logic [NP:0]   ndup;
  logic          t_go, t_m;
  logic [1:0]    t_p;
  int            t_q;
  logic [63:0]   rword;
  logic [13:0]   bytes;
  logic [12:0]   lim;

  // Header words reach the search engine from flops
  for (genvar g = 0; g < sfqe_pkg::HDR_WORDS; g++) begin : g_hdr
    assign sreq_hdr_o[g*64 +: 64] = hdr[g];
  end
  assign rword = rx_data_i[rsel*64 +: 64];
  assign free_blocks_o = fcnt;
  // Stall a block-crossing word while the answer owns the free list
  assign rx_ready_o = (rst == sfqe_pkg::R_RECV &&
                       !(srsp_valid_i && rwc[3:0] == 4'hF)) ?
                      NP'(1) << rsel : '0;
  assign rx_acc = |(rx_ready_o & rx_valid_i);

  // Receive side next state
  always_comb begin
    logic [2:0] lb;
    logic       fnd;
    int         p;
    lb = rx_last_bytes_i[rsel*3 +: 3];
    fnd = 1'b0;
    p = 0;
    next_rst = rst;
    next_rsel = rsel;
    next_rwc = rwc;
    next_rblk = rblk;
    next_rh = rh;
    next_rbad = rbad;
    next_rnb = rnb;
    next_sv = sreq_valid_o && !sreq_ready_i;
    rx_alloc = 1'b0;
    rx_rel = 1'b0;
    rx_ok = 1'b0;
    // [R13] per-port size limit
    bytes = {1'b0, rwc, 3'h0} + ((lb == 3'h0) ? 14'h8 : 14'(lb));
    if (ext_ctrl_i[rsel*8 + sfqe_pkg::EXT_BIG_BIT])
      lim = (buf_limit_i > 13'(sfqe_pkg::BIG_MAX)) ?
            13'(sfqe_pkg::BIG_MAX) : buf_limit_i;
    else
      lim = rx_tagged_i[rsel] ? 13'(sfqe_pkg::TAG_MAX) :
            13'(sfqe_pkg::STD_MAX);
    wr_en = rx_acc && !rbad && rwc < 10'(MW);
    case (rst)
      sfqe_pkg::R_INIT: begin
        next_rblk = rblk + 1'b1;
        // [R12] chain done, whole pool free
        if (rblk == BW'(NBLK - 1)) begin
          next_rst = sfqe_pkg::R_IDLE;
        end
      end
      sfqe_pkg::R_IDLE: begin
        // [R3] round robin among ports with a frame start
        for (int k = 1; k <= NP; k++) begin
          p = (int'(rsel) + k) % NP;
          if (!fnd && rx_valid_i[p] && rx_sof_i[p]) begin
            fnd = 1'b1;
            next_rsel = 2'(p);
          end
        end
        // [R10] one handle per incoming frame
        if (fnd && !sreq_valid_o && fcnt != '0 && !srsp_valid_i) begin
          rx_alloc = 1'b1;
          next_rh = fh;
          next_rblk = fh;
          next_rwc = '0;
          next_rbad = 1'b0;
          next_rnb = (BW+1)'(1);
          next_rst = sfqe_pkg::R_RECV;
        end
      end
      sfqe_pkg::R_RECV: begin
        if (rx_acc) begin
          if (rwc < 10'(MW))
            next_rwc = rwc + 1'b1;
          else
            next_rbad = 1'b1;
          // [R23] cross into a fresh block from the free list
          if (rwc[3:0] == 4'hF && !rx_eof_i[rsel] && !rbad) begin
            if (fcnt != '0) begin
              rx_alloc = 1'b1;
              next_rblk = fh;
              next_rnb = rnb + 1'b1;
            end else begin
              next_rbad = 1'b1;
            end
          end
          // [R2] only good, complete frames are requested
          if (rx_eof_i[rsel]) begin
            rx_ok = rx_good_i[rsel] && !rbad && bytes <= 14'(lim);
            next_sv = rx_ok;
            next_rst = rx_ok ? sfqe_pkg::R_IDLE : sfqe_pkg::R_DROP;
          end
        end
      end
      sfqe_pkg::R_DROP: begin
        if (!srsp_valid_i) begin
          rx_rel = 1'b1;
          next_rst = sfqe_pkg::R_IDLE;
        end
      end
      default: next_rst = sfqe_pkg::R_INIT;
    endcase
  end

  // Admission of a search answer
  always_comb begin
    int         q;
    logic [7:0] tot;
    logic [7:0] ql;
    logic [1:0] s;
    logic       pr;
    q = 0;
    tot = '0;
    pr = 1'b0;
    s = f_src[srsp_handle_i];
    ql = fc_enable_i[s] ? 8'(QH) : queue_limit_i;
    enq = '0;
    next_fc = '0;
    for (int p = 0; p < NP; p++) begin
      q = qidx(p, srsp_class_i);
      tot = ucnt[q] + 8'(mcnt[q]);
      // [R21] protected fast ports never talk to each other
      pr = p < NP - 2 && int'(s) < NP - 2 && protect_i[p] &&
           protect_i[s] && p != int'(s);
      // [R14] queue depth and global reserve decide the drop
      if (srsp_valid_i && srsp_dest_i[p] && !pr &&
          fcnt >= resv_blocks_i && tot < ql &&
          (!srsp_multi_i || mcnt[q] < 3'(MD)) &&
          (srsp_multi_i || enq == '0))
        enq[p] = 1'b1;
      // [R16] pause only a source that allows it
      if (srsp_valid_i && srsp_dest_i[p] && tot >= queue_limit_i &&
          fc_enable_i[s])
        next_fc[s] = 1'b1;
    end
    ndup = (NP+1)'($countones(enq));
    // [R4] nothing admitted means the frame is discarded
    rs_rel = srsp_valid_i && enq == '0;
  end

  // Scheduler and transmit mover next state
  always_comb begin
    logic          fnd;
    logic [BW-1:0] mh;
    int            p;
    int            q;
    fnd = 1'b0;
    p = 0;
    q = 0;
    t_p = trr;
    t_q = 0;
    // [R8] next ready port in turn, [R22] highest busy class
    for (int k = 1; k <= NP; k++) begin
      p = (int'(trr) + k) % NP;
      for (int c = sfqe_pkg::MAX_CLS - 1; c >= 0; c--) begin
        q = p * sfqe_pkg::MAX_CLS + c;
        if (!fnd && tx_ready_i[p] && c < ncls(p) &&
            (ucnt[q] != '0 || mcnt[q] != '0)) begin
          fnd = 1'b1;
          t_p = 2'(p);
          t_q = q;
        end
      end
    end
    t_go = fnd && tst == sfqe_pkg::T_IDLE && !srsp_valid_i;
    mh = mf[t_q*MD + int'(mrd[t_q])];
    // [R7] one logical queue, older head wins
    t_m = mcnt[t_q] != '0 && (ucnt[t_q] == '0 ||
          older(f_stp[mh], f_stp[uhd[t_q]]));
    next_tst = tst;
    next_trr = trr;
    next_th = th;
    next_tblk = tblk;
    next_tsent = tsent;
    next_tp = tx_port_o;
    next_tlen = tx_len_o;
    next_data = tx_data_o;
    next_sof = tx_sof_o;
    next_eof = tx_eof_o;
    next_tv = tx_valid_o && !tx_take_i;
    ld = 1'b0;
    tx_gnt = 1'b0;
    case (tst)
      sfqe_pkg::T_IDLE: begin
        // [R17] frame control info handed to port control
        if (t_go) begin
          next_th = t_m ? mh : uhd[t_q];
          next_tblk = next_th;
          next_tlen = f_len[next_th];
          next_tp = t_p;
          next_trr = t_p;
          next_tsent = '0;
          next_tst = sfqe_pkg::T_SEND;
        end
      end
      sfqe_pkg::T_SEND: begin
        // [R9] [R18] read address walks the block chain
        ld = (!tx_valid_o || tx_take_i) && tsent < tx_len_o;
        if (ld) begin
          next_data = mem[{tblk, tsent[3:0]}];
          next_sof = tsent == '0;
          next_eof = tsent == tx_len_o - 1'b1;
          next_tv = 1'b1;
          next_tsent = tsent + 1'b1;
          if (tsent[3:0] == 4'hF)
            next_tblk = lnk[tblk];
        end else if (tx_valid_o && tx_take_i && tx_eof_o) begin
          next_tst = sfqe_pkg::T_REL;
        end
      end
      sfqe_pkg::T_REL: begin
        // [R19] [R20] release waits behind answer and receive
        tx_gnt = f_dup[th] == (NP+1)'(1) && !srsp_valid_i &&
                 !rx_rel && !rx_alloc;
        if (f_dup[th] != (NP+1)'(1) || tx_gnt)
          next_tst = sfqe_pkg::T_IDLE;
      end
      default: next_tst = sfqe_pkg::T_IDLE;
    endcase
  end

  // Single release port feeding the free list
  always_comb begin
    rel_v = rs_rel || rx_rel || tx_gnt;
    rel_h = rs_rel ? srsp_handle_i : (rx_rel ? rh : th);
    rel_t = rx_rel && !rs_rel ? rblk : f_tl[rel_h];
    rel_n = rx_rel && !rs_rel ? rnb : f_nb[rel_h];
    next_drop = rs_rel || rx_rel;
    // [R12] released chain goes back on the free list head
    if (rel_v)
      next_fh = rel_h;
    else if (rx_alloc)
      next_fh = lnk[fh];
    else if (rst == sfqe_pkg::R_INIT)
      next_fh = '0;
    else
      next_fh = fh;
    next_fcnt = fcnt - (BW+1)'(rx_alloc) + (rel_v ? rel_n : '0);
    if (rst == sfqe_pkg::R_INIT && rblk == BW'(NBLK - 1))
      next_fcnt = (BW+1)'(NBLK);
  end

  // Control registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst <= sfqe_pkg::R_INIT;
      tst <= sfqe_pkg::T_IDLE;
      {rsel, trr, rwc, tsent, rblk, rh, fh, th, tblk} <= '0;
      {rnb, fcnt, rbad, sreq_valid_o, drop_o, fc_o} <= '0;
      {tx_valid_o, tx_port_o, tx_data_o, tx_sof_o} <= '0;
      {tx_eof_o, tx_len_o, sreq_handle_o, sreq_port_o} <= '0;
      stmp <= '0;
    end else begin
      rst <= next_rst;
      tst <= next_tst;
      {rsel, trr, rwc, tsent, rblk, rh} <=
        {next_rsel, next_trr, next_rwc, next_tsent, next_rblk, next_rh};
      {fh, th, tblk, rnb, fcnt, rbad} <=
        {next_fh, next_th, next_tblk, next_rnb, next_fcnt, next_rbad};
      {sreq_valid_o, drop_o, fc_o} <= {next_sv, next_drop, next_fc};
      {tx_valid_o, tx_port_o, tx_data_o, tx_sof_o} <=
        {next_tv, next_tp, next_data, next_sof};
      {tx_eof_o, tx_len_o} <= {next_eof, next_tlen};
      if (rx_ok) begin
        sreq_handle_o <= rh;
        sreq_port_o <= rsel;
      end
      if (enq != '0)
        stmp <= stmp + 1'b1;
    end
  end

  // Queue counters and pointers; answer and pop never share a cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int q = 0; q < NQ; q++) begin
        ucnt[q] <= '0;
        mcnt[q] <= '0;
        mrd[q] <= '0;
        mwr[q] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        // [R6] multicast copies into the physical queue
        if (enq[p] && srsp_multi_i) begin
          mwr[qidx(p, srsp_class_i)] <= mwr[qidx(p, srsp_class_i)] + 1'b1;
          mcnt[qidx(p, srsp_class_i)] <= mcnt[qidx(p, srsp_class_i)] + 1'b1;
        end else if (enq[p]) begin
          ucnt[qidx(p, srsp_class_i)] <= ucnt[qidx(p, srsp_class_i)] + 1'b1;
        end
      end
      if (t_go && t_m) begin
        mrd[t_q] <= mrd[t_q] + 1'b1;
        mcnt[t_q] <= mcnt[t_q] - 1'b1;
      end else if (t_go) begin
        ucnt[t_q] <= ucnt[t_q] - 1'b1;
      end
    end
  end

  // Storage arrays, no reset needed
  always_ff @(posedge sys_clk_i) begin
    if (rst == sfqe_pkg::R_INIT)
      lnk[rblk] <= rblk + 1'b1;
    if (rx_alloc && rst == sfqe_pkg::R_RECV)
      lnk[rblk] <= fh;
    if (rel_v)
      lnk[rel_t] <= fh;
    // [R1] [R11] one 8-byte unit per word, 16 words per block
    if (wr_en)
      mem[{rblk, rwc[3:0]}] <= rword;
    if (wr_en && rwc < 10'(sfqe_pkg::HDR_WORDS))
      hdr[rwc[2:0]] <= rword;
    if (rx_ok) begin
      f_len[rh] <= rwc + 1'b1;
      f_tl[rh] <= rblk;
      f_nb[rh] <= rnb;
      f_src[rh] <= rsel;
    end
    // [R15] copy count and age stamp of an admitted frame
    if (enq != '0) begin
      f_dup[srsp_handle_i] <= ndup;
      f_stp[srsp_handle_i] <= stmp;
    end
    for (int p = 0; p < NP; p++) begin
      if (enq[p] && srsp_multi_i)
        mf[qidx(p, srsp_class_i)*MD + int'(mwr[qidx(p, srsp_class_i)])]
          <= srsp_handle_i;
      else if (enq[p] && ucnt[qidx(p, srsp_class_i)] == '0)
        uhd[qidx(p, srsp_class_i)] <= srsp_handle_i;
      else if (enq[p])
        unx[utl[qidx(p, srsp_class_i)]] <= srsp_handle_i;
      if (enq[p] && !srsp_multi_i)
        utl[qidx(p, srsp_class_i)] <= srsp_handle_i;
    end
    if (t_go && !t_m)
      uhd[t_q] <= unx[uhd[t_q]];
    if (tst == sfqe_pkg::T_REL && next_tst == sfqe_pkg::T_IDLE)
      f_dup[th] <= f_dup[th] - 1'b1;
  end

  sequence s_pick;
    t_go;
  endsequence
  sequence s_first;
    tx_valid_o && tx_sof_o;
  endsequence

  a_good_only: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R2]
    $rose(sreq_valid_o) |-> $past(rx_acc && rx_eof_i[rsel] &&
    rx_good_i[rsel])) else $error("request without good end");
  a_req_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R3]
    sreq_valid_o && !sreq_ready_i |=> sreq_valid_o &&
    $stable(sreq_handle_o)) else $error("request dropped early");
  a_drop_free: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R14]
    srsp_valid_i && enq == '0 |-> rel_v && rel_h == srsp_handle_i)
    else $error("dropped frame not released");
  a_uni_once: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R6]
    srsp_valid_i && !srsp_multi_i |-> $countones(enq) <= 1)
    else $error("unicast queued twice");
  a_fc_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R16]
    |fc_o |-> (fc_o & ~$past(fc_enable_i)) == '0)
    else $error("pause to disabled port");
  a_alloc_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
    rx_alloc |-> fcnt != '0 && !rel_v) else $error("alloc on empty");
  a_pool_size: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R12]
    rst == sfqe_pkg::R_INIT && rblk == BW'(NBLK - 1) |=>
    fcnt == (BW+1)'(NBLK) ##1 fcnt <= (BW+1)'(NBLK))
    else $error("free list size wrong");
  a_sof_first: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R18]
    s_pick |-> ##2 s_first) else $error("first word not start");
  a_tx_release: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R19]
    tx_valid_o && tx_eof_o && tx_take_i && !ld |=>
    tst == sfqe_pkg::T_REL) else $error("no release after end");
endmodule

// ---- src/sfqe_pkg.sv ----
package sfqe_pkg;
  // Data path and buffer geometry
  localparam int UNIT_BYTES  = 8;
  localparam int BLOCK_BYTES = 128;
  localparam int BLK_WORDS   = BLOCK_BYTES / UNIT_BYTES;
  localparam int HDR_BYTES   = 64;
  localparam int HDR_WORDS   = HDR_BYTES / UNIT_BYTES;
  // Frame size limits in bytes
  localparam int STD_MAX     = 1518;
  localparam int TAG_MAX     = 1522;
  localparam int BIG_MAX     = 4096;
  localparam int MAX_WORDS   = BIG_MAX / UNIT_BYTES;
  localparam int EXT_BIG_BIT = 1;
  // Classes per port kind and multicast queue depth
  localparam int FAST_CLS    = 2;
  localparam int WIDE_CLS    = 4;
  localparam int MAX_CLS     = 4;
  localparam int MC_DEPTH    = 4;

  typedef enum logic [3:0] {
    R_INIT = 4'h1,
    R_IDLE = 4'h2,
    R_RECV = 4'h4,
    R_DROP = 4'h8
  } sfqe_rx_type;

  typedef enum logic [2:0] {
    T_IDLE = 3'h1,
    T_SEND = 3'h2,
    T_REL  = 3'h4
  } sfqe_tx_type;
endpackage

// ---- bench/sfqe_search_model.sv ----
`timescale 1ns/10ps
// Search engine stand-in, one request outstanding, answer after a delay
module sfqe_search_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_valid_i,
  input  wire logic [5:0] req_handle_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       multi_i,
  input  wire logic [3:0] dest_i,
  input  wire logic [1:0] class_i,
  output logic            req_ready_o,
  output logic            rsp_valid_o,
  output logic [5:0]      rsp_handle_o,
  output logic            rsp_multi_o,
  output logic [3:0]      rsp_dest_o,
  output logic [1:0]      rsp_class_o
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic [5:0] hnd;
  // answer gives cast and ports; junk on the lines otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_ready_o  <= 1'b1;
      busy         <= 1'b0;
      wait_cnt     <= 4'h0;
      hnd          <= 6'h00;
      rsp_valid_o  <= 1'b0;
      rsp_handle_o <= 6'h00;
      rsp_multi_o  <= 1'b0;
      rsp_dest_o   <= 4'h0;
      rsp_class_o  <= 2'h0;
    end else begin
      rsp_valid_o  <= 1'b0;
      rsp_handle_o <= ~hnd;
      rsp_multi_o  <= ~multi_i;
      rsp_dest_o   <= ~dest_i;
      rsp_class_o  <= ~class_i;
      if (req_valid_i && req_ready_o) begin
        busy        <= 1'b1;
        req_ready_o <= 1'b0;
        wait_cnt    <= delay_i;
        hnd         <= req_handle_i;
      end else if (busy) begin
        if (wait_cnt == 4'h0) begin
          busy         <= 1'b0;
          req_ready_o  <= 1'b1;
          rsp_valid_o  <= 1'b1;
          rsp_handle_o <= hnd;
          rsp_multi_o  <= multi_i;
          rsp_dest_o   <= dest_i;
          rsp_class_o  <= class_i;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic         clk = 0, rst = 1, sreq_v, sreq_rdy, rsp_v, rsp_m, mul;
  logic         drop, txv, txs, txe, take = 0;
  logic [3:0]   rxv = 0, sof = 0, eof = 0, good = 0, tag = 0, rxr, dest;
  logic [3:0]   rsp_d, fce = 0, prot = 0, fc, txr = 0, dly = 4'h2;
  logic [255:0] rxd = 0;
  logic [5:0]   hnd, rsp_h;
  logic [1:0]   sport, rsp_c, cls, txp;
  logic [511:0] hdr;
  logic [6:0]   freeb;
  logic [63:0]  txd;
  logic [9:0]   txl;
  logic [7:0]   qlim = 8'h08;
  int           held = 0;
  logic [31:0]  base[4];
  integer       seed = 32'hfdf2, miscompares = 0, tests_run = 0, i;
  always #2 clk = ~clk;
  sfqe_engine dut (.sys_clk_i(clk), .rst_i(rst), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_sof_i(sof), .rx_eof_i(eof), .rx_good_i(good),
    .rx_tagged_i(tag), .rx_last_bytes_i(12'h000), .rx_ready_o(rxr),
    .sreq_valid_o(sreq_v), .sreq_ready_i(sreq_rdy), .sreq_handle_o(hnd),
    .sreq_port_o(sport), .sreq_hdr_o(hdr), .srsp_valid_i(rsp_v),
    .srsp_handle_i(rsp_h), .srsp_multi_i(rsp_m), .srsp_dest_i(rsp_d),
    .srsp_class_i(rsp_c), .fc_enable_i(fce), .protect_i(prot),
    .ext_ctrl_i(32'h00000000), .buf_limit_i(13'h1000),
    .resv_blocks_i(7'h01), .queue_limit_i(qlim), .fc_o(fc),
    .drop_o(drop), .free_blocks_o(freeb), .tx_ready_i(txr),
    .tx_take_i(take), .tx_valid_o(txv), .tx_port_o(txp), .tx_data_o(txd),
    .tx_sof_o(txs), .tx_eof_o(txe), .tx_len_o(txl));
  sfqe_search_model far (.clk_i(clk), .rst_i(rst), .req_valid_i(sreq_v),
    .req_handle_i(hnd), .delay_i(dly), .multi_i(mul), .dest_i(dest),
    .class_i(cls), .req_ready_o(sreq_rdy), .rsp_valid_o(rsp_v),
    .rsp_handle_o(rsp_h), .rsp_multi_o(rsp_m), .rsp_dest_o(rsp_d),
    .rsp_class_o(rsp_c));
  // Expected word k of frame f, derived from its random base
  function automatic logic [63:0] fw(input int f, input int k);
    return {base[f] + k, base[f] ^ k};
  endfunction
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic summarize;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Feed one frame, word advances only when it was taken
  task automatic send(input int p, input int n, input int f,
                      input logic ok);
    int k;
    k = 0;
    @(posedge clk);
    while (k < n) begin
      rxv[p] <= 1'b1;
      sof[p] <= (k == 0);
      eof[p] <= (k == n - 1);
      good[p] <= ok;
      tag[p] <= 1'($random(seed));
      rxd[p*64 +: 64] <= fw(f, k);
      @(negedge clk);
      if (rxr[p] === 1'b1) k++;
      @(posedge clk);
    end
    rxv[p] <= 1'b0;
    eof[p] <= 1'b0;
  endtask
  // Frame in, request checked, answer given
  task automatic frame_in(input int p, input int n, input int f);
    int t;
    send(p, n, f, 1'b1);
    t = 0;
    @(negedge clk);
    while (sreq_v !== 1'b1 && t < 20) begin @(negedge clk); t++; end
    check("sreq_port", sport, p);
    check("hdr_word0", hdr[63:0], fw(f, 0));
    if (n >= 8) check("hdr_word7", hdr[511:448], fw(f, 7));
    // Blocks of frames still queued elsewhere are counted in held
    check("free_held", freeb, 64 - held - (n + 15) / 16);
    repeat (12) @(negedge clk);
  endtask
  // Collect one frame with random stalls between takes
  task automatic recv(input int port, input int n, input int f);
    int k, t;
    t = 0;
    @(negedge clk);
    while (txv !== 1'b1 && t < 500) begin @(negedge clk); t++; end
    check("tx_port", txp, port);
    check("tx_len", txl, n);
    for (k = 0; k < n; k++) begin
      check("tx_sof", txs, k == 0);
      check("tx_eof", txe, k == n - 1);
      check("tx_data", txd, fw(f, k));
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      @(posedge clk);
      take <= 1'b1;
      @(posedge clk);
      take <= 1'b0;
      @(negedge clk);
    end
  endtask
  // Watch drop and pause pulses over a window after the answer
  task automatic drop_seen(input logic exp, input logic [3:0] efc);
    logic       d;
    logic [3:0] f;
    d = 1'b0;
    f = 4'h0;
    repeat (16) begin
      @(negedge clk);
      d |= drop;
      f |= fc;
    end
    check("drop", d, exp);
    check("fc", f, efc);
  endtask
  // Whole run is under two thousand cycles; this is a hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    for (i = 0; i < 4; i++) base[i] = $random(seed);
    mul = 0; dest = 4'h2; cls = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    fce <= 4'($random(seed));
    @(negedge clk);
    check("free_init", freeb, 0);
    repeat (66) @(negedge clk);
    check("free_ready", freeb, 64);
    txr <= 4'hF;
    // Unicast frames, one single word and three over block edges
    for (i = 0; i < 4; i++) begin
      dest <= 4'h1 << ((i + 1) % 4);
      cls <= 2'($random(seed));
      dly <= 4'($random(seed));
      frame_in(i, (i == 0) ? 1 : 15 + i * 9, i);
      recv((i + 1) % 4, (i == 0) ? 1 : 15 + i * 9, i);
      repeat (6) @(negedge clk);
      check("free_back", freeb, 64);
    end
    // Bad status frame is drained and dropped
    send(1, 5, 2, 1'b0);
    drop_seen(1'b1, 4'h0);
    check("free_bad", freeb, 64);
    // 1528 bytes is over either size limit
    send(0, 191, 1, 1'b1);
    drop_seen(1'b1, 4'h0);
    check("free_big", freeb, 64);
    // protected pair never forwards; slow answer lands in window
    dly <= 4'hF;
    prot <= 4'h3;
    dest <= 4'h2;
    frame_in(0, 3, 1);
    drop_seen(1'b1, 4'h0);
    prot <= 4'h0;
    // enabled source over its soft limit is paused, not dropped
    fce <= 4'h1;
    qlim <= 8'h00;
    frame_in(0, 2, 0);
    drop_seen(1'b0, 4'h1);
    qlim <= 8'h08;
    recv(1, 2, 0);
    // higher class queue leaves first; quick answers needed
    dly <= 4'h2;
    txr <= 4'h0;
    dest <= 4'h8;
    cls <= 2'h0;
    frame_in(0, 4, 0);
    cls <= 2'h3;
    held = 1;
    frame_in(1, 6, 3);
    held = 0;
    txr <= 4'h8;
    recv(3, 6, 3);
    recv(3, 4, 0);
    // multicast copies each reach their port
    mul <= 1'b1;
    dest <= 4'hC;
    txr <= 4'h0;
    frame_in(2, 18, 2);
    txr <= 4'h4;
    recv(2, 18, 2);
    txr <= 4'h8;
    recv(3, 18, 2);
    repeat (6) @(negedge clk);
    check("free_mc", freeb, 64);
    summarize();
  end
endmodule
